// ===== pss_status_regs.sv
// pss_status_regs: link, transfer and thermistor status registers of a line-powered slave
// assumes: link engine and thermistor comparators are synchronous to core_clk; plain strobe port
`timescale 1ns/1ps
`default_nettype none
module pss_status_regs #(
    parameter logic [7:0] HW_REVISION_CODE = 8'h5a // arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // live link state from the line engine
    input wire logic [1:0] link_state,
    input wire logic short_xfer_active,
    input wire logic long_xfer_active,
    // thermistor comparators and line detector
    input wire logic thm_disconnected,
    input wire logic [2:0] thm_zone,
    input wire logic line_voltage_ok,
    // measured adc values
    input wire logic [7:0] adc_average,
    input wire logic [7:0] adc_maximum,
    input wire logic [7:0] adc_minimum,
    // config outputs and interrupt line
    output logic [2:0] thermistor_monitor_enable,
    output logic [7:0] cfg_adc_ground_retry,
    output logic [7:0] cfg_adc_range,
    output logic [7:0] cfg_adc_averaging,
    output logic [7:0] cfg_adc_noise,
    output logic [7:0] cfg_moist_mult,
    output logic [7:0] cfg_moist_thresh,
    output logic [7:0] cfg_moist_ctrl,
    output logic [7:0] cfg_input_res,
    output logic irq
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [7:0] cfg_mask(input logic [2:0] idx);
        case (idx)
            3'h0: cfg_mask = pss_pkg::MASK_ADC_GROUND_RETRY;
            3'h1: cfg_mask = pss_pkg::MASK_ADC_RANGE;
            3'h2: cfg_mask = pss_pkg::MASK_ADC_AVERAGING;
            3'h3: cfg_mask = pss_pkg::MASK_ADC_NOISE;
            3'h4: cfg_mask = pss_pkg::MASK_MOIST_MULT;
            3'h5: cfg_mask = pss_pkg::MASK_MOIST_THRESH;
            3'h6: cfg_mask = pss_pkg::MASK_MOIST_CTRL;
            default: cfg_mask = pss_pkg::MASK_INPUT_RES;
        endcase
    endfunction

    pss_pkg::pss_bus_req_s req;
    pss_pkg::pss_thermal_s thm_in;
    pss_pkg::pss_status_s live;
    pss_pkg::pss_status_s status_reg;
    pss_pkg::pss_zone_e zone_next;
    pss_pkg::pss_link_e link;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign thm_in = '{thm_disconnected: thm_disconnected, thm_zone: thm_zone,
                      line_voltage_ok: line_voltage_ok};
    assign link = pss_pkg::pss_link_e'(link_state);

    // thermistor monitor enable, writable by software
    logic [2:0] thm_en_reg;
    logic [2:0] thm_en_next;

    // zone priority: disabled beats no line voltage beats missing thermistor
    always_comb begin
        if (thm_en_reg == pss_pkg::THM_EN_OFF) begin
            zone_next = pss_pkg::PSS_ZONE_MON_DISABLED;
        end else if (!thm_in.line_voltage_ok) begin
            zone_next = pss_pkg::PSS_ZONE_NO_LINE_VOLTAGE;
        end else if (thm_in.thm_disconnected) begin
            zone_next = pss_pkg::PSS_ZONE_NO_THERMISTOR;
        end else begin
            case (thm_in.thm_zone)
                3'h0: zone_next = pss_pkg::PSS_ZONE_COLD;
                3'h1: zone_next = pss_pkg::PSS_ZONE_COOL;
                3'h2: zone_next = pss_pkg::PSS_ZONE_ROOM;
                3'h3: zone_next = pss_pkg::PSS_ZONE_WARM;
                // comparator codes past hot clamp to hot
                default: zone_next = pss_pkg::PSS_ZONE_HOT;
            endcase
        end
    end

    // live flags, registered once; no latching of past events
    assign live.connected = (link == pss_pkg::PSS_LINK_CONNECTED);
    assign live.waiting = (link == pss_pkg::PSS_LINK_WAITING);
    assign live.idle = (link == pss_pkg::PSS_LINK_IDLE);
    assign live.short_xfer = short_xfer_active;
    assign live.long_xfer = long_xfer_active;
    assign live.zone = zone_next;

    logic [7:0] status_byte;
    assign status_byte = {status_reg.connected, status_reg.waiting, status_reg.idle,
                          status_reg.short_xfer, status_reg.long_xfer, status_reg.zone};

    // interrupts: events from the registered status
    logic [4:0] irq_status_reg;
    logic [4:0] irq_status_next;
    logic [4:0] irq_enable_reg;
    logic [4:0] irq_enable_next;
    logic [4:0] irq_events;

    assign irq_events[pss_pkg::IRQ_CONNECT] = live.connected & ~status_reg.connected;
    assign irq_events[pss_pkg::IRQ_DISCONNECT] = ~live.connected & status_reg.connected;
    assign irq_events[pss_pkg::IRQ_SHORT_DONE] = ~live.short_xfer & status_reg.short_xfer;
    assign irq_events[pss_pkg::IRQ_LONG_DONE] = ~live.long_xfer & status_reg.long_xfer;
    assign irq_events[pss_pkg::IRQ_ZONE_CHANGE] = (live.zone != status_reg.zone);

    // address decode
    wire wr_irq_clear = req.wr & hit(req.addr, pss_pkg::OFF_IRQ_CLEAR);
    wire wr_irq_enable = req.wr & hit(req.addr, pss_pkg::OFF_IRQ_ENABLE);
    wire wr_thm_en = req.wr & hit(req.addr, pss_pkg::OFF_THM_MON_ENABLE);
    wire cfg_wr_hit = req.wr & (req.addr >= pss_pkg::CFG_BASE) & (req.addr <= pss_pkg::CFG_LAST);
    wire cfg_rd_hit = (reg_addr >= pss_pkg::CFG_BASE) & (reg_addr <= pss_pkg::CFG_LAST);
    wire [7:0] cfg_off = req.addr - pss_pkg::CFG_BASE;
    wire [2:0] cfg_idx = cfg_off[2:0];

    // set wins over clear
    assign irq_status_next = (irq_status_reg & ~(wr_irq_clear ? req.wdata[4:0] :
                              pss_pkg::IRQ_RESET)) | irq_events;
    assign irq_enable_next = wr_irq_enable ? req.wdata[4:0] : irq_enable_reg;
    assign thm_en_next = wr_thm_en ? req.wdata[2:0] : thm_en_reg;
    assign irq = |(irq_status_reg & irq_enable_reg);

    // config bank lives in its own memory; a shadow copy drives the outputs
    logic [7:0] cfg_rdata;
    logic [7:0] cfg_shadow_reg [pss_pkg::CFG_COUNT];
    pss_cfg_mem #(
        .DEPTH(pss_pkg::CFG_COUNT),
        .AW(3),
        .DW(8)
    ) u_cfg (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_en(cfg_wr_hit),
        .wr_addr(cfg_idx),
        .wr_data(req.wdata & cfg_mask(cfg_idx)),
        .rd_addr(cfg_idx),
        .rd_data(cfg_rdata)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < pss_pkg::CFG_COUNT; i++) begin
                cfg_shadow_reg[i] <= pss_pkg::ZERO_BYTE;
            end
        end else if (cfg_wr_hit) begin
            cfg_shadow_reg[cfg_idx] <= req.wdata & cfg_mask(cfg_idx);
        end
    end

    assign cfg_adc_ground_retry = cfg_shadow_reg[0];
    assign cfg_adc_range = cfg_shadow_reg[1];
    assign cfg_adc_averaging = cfg_shadow_reg[2];
    assign cfg_adc_noise = cfg_shadow_reg[3];
    assign cfg_moist_mult = cfg_shadow_reg[4];
    assign cfg_moist_thresh = cfg_shadow_reg[5];
    assign cfg_moist_ctrl = cfg_shadow_reg[6];
    assign cfg_input_res = cfg_shadow_reg[7];
    assign thermistor_monitor_enable = thm_en_reg;

    // read mux; revision and status have no write path at all
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = pss_pkg::ZERO_BYTE;
        case (reg_addr)
            pss_pkg::OFF_HW_REVISION: rd_mux = HW_REVISION_CODE;
            pss_pkg::OFF_LINK_THERMAL_STATUS: rd_mux = status_byte;
            pss_pkg::OFF_ADC_AVERAGE: rd_mux = adc_average;
            pss_pkg::OFF_ADC_MAXIMUM: rd_mux = adc_maximum;
            pss_pkg::OFF_ADC_MINIMUM: rd_mux = adc_minimum;
            pss_pkg::OFF_IRQ_STATUS: rd_mux = {3'h0, irq_status_reg};
            pss_pkg::OFF_IRQ_ENABLE: rd_mux = {3'h0, irq_enable_reg};
            pss_pkg::OFF_THM_MON_ENABLE: rd_mux = {5'h00, thm_en_reg};
            default: rd_mux = pss_pkg::ZERO_BYTE;
        endcase
    end

    // cfg data arrive from the memory's own register, so select them one cycle late
    logic rd_cfg_reg;
    logic rd_valid_reg;
    logic [7:0] rd_hold_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_reg <= pss_pkg::pss_status_s'(pss_pkg::STATUS_RESET);
            irq_status_reg <= pss_pkg::IRQ_RESET;
            irq_enable_reg <= pss_pkg::IRQ_RESET;
            thm_en_reg <= pss_pkg::THM_EN_RESET;
            rd_cfg_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            rd_hold_reg <= pss_pkg::ZERO_BYTE;
        end else begin
            status_reg <= live;
            irq_status_reg <= irq_status_next;
            irq_enable_reg <= irq_enable_next;
            thm_en_reg <= thm_en_next;
            rd_cfg_reg <= req.rd & cfg_rd_hit;
            rd_valid_reg <= req.rd;
            // hold zero between reads so a stale byte never leaks onto the port
            rd_hold_reg <= req.rd ? rd_mux : pss_pkg::ZERO_BYTE;
        end
    end

    assign reg_rdata = !rd_valid_reg ? pss_pkg::ZERO_BYTE :
                       rd_cfg_reg ? cfg_rdata : rd_hold_reg;
endmodule
`default_nettype wire

// ===== pss_pkg.sv
// pss_pkg: register map, field layout and enumerations for the slave status register bank
// assumes: 8-bit registers on a plain strobe port, one clock, synchronous active-low reset
package pss_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFF_HW_REVISION = 8'h00;
    localparam logic [7:0] OFF_LINK_THERMAL_STATUS = 8'h01;
    localparam logic [7:0] OFF_ADC_GROUND_RETRY = 8'h70;
    localparam logic [7:0] OFF_ADC_RANGE = 8'h71;
    localparam logic [7:0] OFF_ADC_AVERAGING = 8'h72;
    localparam logic [7:0] OFF_ADC_NOISE = 8'h73;
    localparam logic [7:0] OFF_MOIST_MULT = 8'h74;
    localparam logic [7:0] OFF_MOIST_THRESH = 8'h75;
    localparam logic [7:0] OFF_MOIST_CTRL = 8'h76;
    localparam logic [7:0] OFF_INPUT_RES = 8'h77;
    localparam logic [7:0] OFF_ADC_AVERAGE = 8'h78;
    localparam logic [7:0] OFF_ADC_MAXIMUM = 8'h79;
    localparam logic [7:0] OFF_ADC_MINIMUM = 8'h7a;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h81;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h82;
    localparam logic [7:0] OFF_THM_MON_ENABLE = 8'h83;

    // config base for the rw bank at 0x70..0x77
    localparam logic [7:0] CFG_BASE = 8'h70;
    localparam int CFG_COUNT = 8;
    localparam logic [7:0] CFG_LAST = 8'h77;
    localparam logic [7:0] VAL_LAST = 8'h7a;

    // writable-bit masks of the config bank
    localparam logic [7:0] MASK_ADC_GROUND_RETRY = 8'h7f;
    localparam logic [7:0] MASK_ADC_RANGE = 8'h3f;
    localparam logic [7:0] MASK_ADC_AVERAGING = 8'h07;
    localparam logic [7:0] MASK_ADC_NOISE = 8'h3f;
    localparam logic [7:0] MASK_MOIST_MULT = 8'h03;
    localparam logic [7:0] MASK_MOIST_THRESH = 8'hff;
    localparam logic [7:0] MASK_MOIST_CTRL = 8'h55;
    localparam logic [7:0] MASK_INPUT_RES = 8'h03;

    // status field positions
    localparam int BIT_CONNECTED = 7;
    localparam int BIT_WAITING = 6;
    localparam int BIT_IDLE = 5;
    localparam int BIT_SHORT_XFER = 4;
    localparam int BIT_LONG_XFER = 3;
    localparam int THM_W = 3;
    localparam int THM_EN_W = 3;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [2:0] THM_EN_OFF = 3'h0;
    localparam logic [2:0] THM_EN_RESET = 3'h0;

    // interrupt event bits
    localparam int IRQ_W = 5;
    localparam int IRQ_CONNECT = 0;
    localparam int IRQ_DISCONNECT = 1;
    localparam int IRQ_SHORT_DONE = 2;
    localparam int IRQ_LONG_DONE = 3;
    localparam int IRQ_ZONE_CHANGE = 4;
    localparam logic [4:0] IRQ_RESET = 5'h00;

    typedef enum logic [2:0] {
        PSS_ZONE_COLD = 3'h0,
        PSS_ZONE_COOL = 3'h1,
        PSS_ZONE_ROOM = 3'h2,
        PSS_ZONE_WARM = 3'h3,
        PSS_ZONE_HOT = 3'h4,
        PSS_ZONE_NO_THERMISTOR = 3'h5,
        PSS_ZONE_MON_DISABLED = 3'h6,
        PSS_ZONE_NO_LINE_VOLTAGE = 3'h7
    } pss_zone_e;

    typedef enum logic [1:0] {
        PSS_LINK_IDLE = 2'h0,
        PSS_LINK_WAITING = 2'h1,
        PSS_LINK_CONNECTED = 2'h2
    } pss_link_e;

    // live state that the block's own logic reports
    typedef struct packed {
        logic connected;
        logic waiting;
        logic idle;
        logic short_xfer;
        logic long_xfer;
        logic [2:0] zone;
    } pss_status_s;

    // inputs from the analog thermistor comparators and line detector
    typedef struct packed {
        logic thm_disconnected;
        logic [2:0] thm_zone;
        logic line_voltage_ok;
    } pss_thermal_s;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pss_bus_req_s;

endpackage

// ===== pss_cfg_mem.sv
// pss_cfg_mem: small register file for the adc and moisture config bank
// assumes: one write port, registered read data, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pss_cfg_mem #(
    parameter int DEPTH = 8,
    parameter int AW = 3,
    parameter int DW = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_reg [DEPTH];
    logic [DW-1:0] rd_data_reg;

    // reset to zero so read-back is defined before software programs the bank
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            rd_data_reg <= '0;
        end else begin
            if (wr_en) begin
                mem_reg[wr_addr] <= wr_data;
            end
            rd_data_reg <= mem_reg[rd_addr];
        end
    end

    assign rd_data = rd_data_reg;
endmodule
`default_nettype wire

// ===== pss_status_regs_checker.sv
// pss_status_regs_checker: port-level checks of the slave status register bank
// assumes: bound into pss_status_regs; one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pss_status_regs_checker #(
    parameter logic [7:0] HW_REVISION_CODE = 8'h5a
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] link_state,
    input wire logic short_xfer_active,
    input wire logic long_xfer_active,
    input wire logic thm_disconnected,
    input wire logic [2:0] thm_zone,
    input wire logic line_voltage_ok,
    input wire logic [2:0] thermistor_monitor_enable,
    input wire logic [7:0] cfg_adc_range
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] zone_exp;
    logic [7:0] st_exp;
    logic [7:0] st_q;
    logic [1:0] calm;
    logic st_rd;
    // disabled beats missing line voltage, which beats a missing thermistor
    assign zone_exp = (thermistor_monitor_enable == 3'h0) ? 3'h6 :
        !line_voltage_ok ? 3'h7 : thm_disconnected ? 3'h5 :
        (thm_zone > 3'h4) ? 3'h4 : thm_zone;
    assign st_exp = {link_state == 2'h2, link_state == 2'h1, link_state == 2'h0,
        short_xfer_active, long_xfer_active, zone_exp};
    // only judge reads whose inputs sat still long enough to reach the register
    assign st_rd = reg_rd && reg_addr == 8'h01 && calm == 2'h3 && st_exp == st_q;
    always_ff @(posedge core_clk) begin
        st_q <= st_exp;
        if (!rst_n || st_exp != st_q) calm <= 2'h0;
        else if (calm != 2'h3) calm <= calm + 2'h1;
    end
    a_link_flags: assert property (st_rd |=> reg_rdata[7:6] == $past(st_exp[7:6]))
        else $error("link flags wrong");
    a_idle_flag: assert property (st_rd |=> reg_rdata[5] == $past(st_exp[5]))
        else $error("idle flag wrong");
    a_short_flag: assert property (st_rd |=> reg_rdata[4] == $past(st_exp[4]))
        else $error("short transfer flag wrong");
    a_long_flag: assert property (st_rd |=> reg_rdata[3] == $past(st_exp[3]))
        else $error("long transfer flag wrong");
    a_zone_code: assert property (st_rd |=> reg_rdata[2:0] == $past(st_exp[2:0]))
        else $error("zone code wrong");
    a_rev_code: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == HW_REVISION_CODE)
        else $error("revision code wrong");
    a_read_quiet: assert property (reg_rd |=> $stable(thermistor_monitor_enable))
        else $error("read changed a setting");
    a_ro_write: assert property (reg_wr && reg_addr <= 8'h01 |=>
        $stable(thermistor_monitor_enable) && $stable(cfg_adc_range))
        else $error("read-only write took effect");
    a_rdata_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule
bind pss_status_regs pss_status_regs_checker #(.HW_REVISION_CODE(HW_REVISION_CODE)) i_chk (
    .core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .link_state,
    .short_xfer_active, .long_xfer_active, .thm_disconnected, .thm_zone,
    .line_voltage_ok, .thermistor_monitor_enable, .cfg_adc_range
);
`default_nettype wire

// ===== pss_line_model.sv
// pss_line_model: far-side line engine and thermistor front end
// assumes: bench requests link state and transfers; thermal values pass straight through
`timescale 1ns/1ps
`default_nettype none
module pss_line_model #(
    parameter int WAIT_CYC = 4,
    parameter int XFER_CYC = 6
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] link_req,
    input wire logic go_short,
    input wire logic go_long,
    input wire pss_pkg::pss_thermal_s therm,
    output logic [1:0] link_state,
    output logic short_xfer_active,
    output logic long_xfer_active,
    output logic thm_disconnected,
    output logic [2:0] thm_zone,
    output logic line_voltage_ok
);
    int wait_cnt;
    int s_cnt;
    int l_cnt;
    assign {thm_disconnected, thm_zone, line_voltage_ok} = therm;
    assign short_xfer_active = s_cnt != 0;
    assign long_xfer_active = l_cnt != 0;
    // a connection always passes through waiting, as the real handshake does
    always_ff @(posedge core_clk) begin
        if (!rst_n || link_req != 2'h2) begin
            link_state <= rst_n ? link_req : 2'h0;
            wait_cnt <= 0;
        end else if (wait_cnt < WAIT_CYC) begin
            link_state <= 2'h1;
            wait_cnt <= wait_cnt + 1;
        end else begin
            link_state <= 2'h2;
        end
        s_cnt <= !rst_n ? 0 : go_short ? XFER_CYC : (s_cnt != 0) ? s_cnt - 1 : 0;
        l_cnt <= !rst_n ? 0 : go_long ? XFER_CYC : (l_cnt != 0) ? l_cnt - 1 : 0;
    end
endmodule
`default_nettype wire

// ===== testbench.sv
// testbench: table-driven and hand-written checks of the status register bank
// assumes: pss_line_model on the far side; plain strobe register port driven here
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] REV = 8'hc3; // arbitrary revision value
    typedef struct packed {
        logic [1:0] link;
        pss_pkg::pss_thermal_s th;
        logic [2:0] en;
        logic [7:0] exp;
    } pss_row_s;
    pss_row_s rows [11] = '{'{2'h0, 5'h05, 3'h1, 8'h22}, '{2'h1, 5'h01, 3'h1, 8'h40},
        '{2'h2, 5'h03, 3'h1, 8'h81}, '{2'h3, 5'h07, 3'h1, 8'h03}, '{2'h0, 5'h09, 3'h1, 8'h24},
        '{2'h0, 5'h0d, 3'h1, 8'h24}, '{2'h0, 5'h15, 3'h1, 8'h25}, '{2'h0, 5'h05, 3'h0, 8'h26},
        '{2'h0, 5'h04, 3'h1, 8'h27}, '{2'h0, 5'h14, 3'h4, 8'h27}, '{2'h0, 5'h04, 3'h0, 8'h26}};
    logic core_clk, rst_n, reg_wr, reg_rd, go_short, go_long, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] link_req, link_state;
    logic short_xfer_active, long_xfer_active, thm_disconnected, line_voltage_ok;
    logic [2:0] thm_zone;
    pss_pkg::pss_thermal_s therm;
    logic [2:0] thm_en_q;
    logic [7:0][7:0] cfg_q;
    logic [7:0] cfg_masks [8] = '{pss_pkg::MASK_ADC_GROUND_RETRY, pss_pkg::MASK_ADC_RANGE,
        pss_pkg::MASK_ADC_AVERAGING, pss_pkg::MASK_ADC_NOISE, pss_pkg::MASK_MOIST_MULT,
        pss_pkg::MASK_MOIST_THRESH, pss_pkg::MASK_MOIST_CTRL, pss_pkg::MASK_INPUT_RES};
    int miscompares = 0;
    int num_checks = 0;
    pss_line_model i_pss_line_model (.core_clk, .rst_n, .link_req, .go_short, .go_long,
        .therm, .link_state, .short_xfer_active, .long_xfer_active, .thm_disconnected,
        .thm_zone, .line_voltage_ok);
    pss_status_regs #(.HW_REVISION_CODE(REV)) i_pss_status_regs (.core_clk, .rst_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_state,
        .short_xfer_active, .long_xfer_active, .thm_disconnected, .thm_zone,
        .line_voltage_ok, .adc_average(8'h3c), .adc_maximum(8'h96), .adc_minimum(8'hc5),
        .thermistor_monitor_enable(thm_en_q), .cfg_adc_ground_retry(cfg_q[0]),
        .cfg_adc_range(cfg_q[1]), .cfg_adc_averaging(cfg_q[2]), .cfg_adc_noise(cfg_q[3]),
        .cfg_moist_mult(cfg_q[4]), .cfg_moist_thresh(cfg_q[5]), .cfg_moist_ctrl(cfg_q[6]),
        .cfg_input_res(cfg_q[7]), .irq);
    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so look there
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
        // end on an edge so whatever the caller drives next lands on one
        @(posedge core_clk);
    endtask
    task automatic irq_is(input logic v);
        @(posedge core_clk);
        #1;
        chk("irq", {7'h00, v}, {7'h00, irq});
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        $display("BAD watchdog expected finish seen hang");
        results();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, go_short, go_long, reg_addr, reg_wdata} = '0;
        link_req = 2'h0;
        therm = 5'h00;
        idle(10);
        chk("rdata in reset", 8'h00, reg_rdata);
        rst_n <= 1'b1;
        rd(8'h01, 8'h26, "status after reset");
        rd(8'h83, 8'h00, "enable after reset");
        $display("test reset finished");
        foreach (rows[i]) begin
            link_req <= rows[i].link;
            therm <= rows[i].th;
            wr(8'h83, {5'h00, rows[i].en});
            idle(8);
            chk("monitor enable", {5'h00, rows[i].en}, {5'h00, thm_en_q});
            rd(8'h01, rows[i].exp, "status row");
            rd(8'h01, rows[i].exp, "status reread");
        end
        $display("test table finished");
        link_req <= 2'h2;
        therm <= 5'h05;
        wr(8'h83, 8'h01);
        idle(8);
        rd(8'h80, 8'h13, "events before clear");
        wr(8'h81, 8'h1f);
        wr(8'h82, 8'h04);
        go_short <= 1'b1;
        go_long <= 1'b1;
        idle(1);
        {go_short, go_long} <= 2'b00;
        rd(8'h01, 8'h9a, "both transfers");
        idle(10);
        rd(8'h01, 8'h82, "transfers over");
        irq_is(1'b1);
        rd(8'h80, 8'h0c, "event status");
        wr(8'h82, 8'h00);
        irq_is(1'b0);
        wr(8'h82, 8'h04);
        irq_is(1'b1);
        wr(8'h81, 8'h04);
        irq_is(1'b0);
        rd(8'h80, 8'h08, "event after clear");
        $display("test transfers and interrupt finished");
        wr(8'h00, 8'hff);
        wr(8'h01, 8'h00);
        rd(8'h00, REV, "revision");
        rd(8'h01, 8'h82, "status after write");
        wr(8'h72, 8'hff);
        rd(8'h72, 8'h07, "averaging config");
        foreach (cfg_masks[i]) begin
            wr(pss_pkg::CFG_BASE + 8'(i), 8'hff);
            rd(pss_pkg::CFG_BASE + 8'(i), cfg_masks[i], "config readback");
            chk("config pin", cfg_masks[i], cfg_q[i]);
        end
        rd(8'h78, 8'h3c, "adc average");
        rd(8'h79, 8'h96, "adc maximum");
        rd(8'h7a, 8'hc5, "adc minimum");
        rd(8'h81, 8'h00, "clear reads zero");
        wr(8'h90, 8'hff);
        rd(8'h90, 8'h00, "unmapped");
        $display("test map finished");
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        rd(8'h82, 8'h00, "enable after second reset");
        $display("test second reset finished");
        results();
    end
endmodule
`default_nettype wire
